// ==== tk_cfg.svh ====
`ifndef TK_CFG_SVH
`define TK_CFG_SVH

// Register byte addresses
`define TK_ADDR_CTRL 12'h000
`define TK_ADDR_STATUS 12'h004
`define TK_ADDR_INT_STAT 12'h008
`define TK_ADDR_INT_MASK 12'h00C

// Control register fields
`define TK_CTRL_OVR 0
`define TK_CTRL_SCOPE 1
`define TK_CTRL_STYLE 2
`define TK_CTRL_RST 3'h0

// Interrupt status layout: bits 7..0 touches, bit 8 serial command
`define TK_INT_CMD 8
`define TK_INT_RST 9'h000
`define TK_MASK_RST 9'h000

// Timing
`define TK_CLK_PERIOD_PS 5000
`define TK_BIT_TIME_NS 10000
`define TK_BIT_CYCLES ((`TK_BIT_TIME_NS * 1000) / `TK_CLK_PERIOD_PS)
`define TK_STRAP_WAIT 2'h2

// Serial frame lengths
`define TK_STAT_LAST 3'h7
`define TK_CMD_LAST 3'h2

`endif

// ==== tk_pkg.sv ====
package tk_pkg;

  typedef logic [7:0] tk_keys_t;
  typedef logic [11:0] tk_addr_t;
  typedef logic [31:0] tk_data_t;

  typedef enum logic [1:0] {
    SER_IDLE,
    SER_START,
    SER_SEND,
    SER_CMD
  } tk_ser_t;

  // One-cycle pulse on a low-to-high change of each bit
  function automatic tk_keys_t tk_rise(input tk_keys_t cur,
                                       input tk_keys_t prev);
    tk_rise = cur & ~prev;
  endfunction : tk_rise

  // Word-aligned register decode
  function automatic logic tk_mapped(input tk_addr_t a);
    tk_mapped = (a == 12'h000) || (a == 12'h004) ||
                (a == 12'h008) || (a == 12'h00C);
  endfunction : tk_mapped

endpackage : tk_pkg

// ==== tk_if.sv ====
`timescale 1ns/10ps
interface tk_if;
  import tk_pkg::*;
  tk_keys_t touched;
  logic toggle;
  tk_keys_t active;
  tk_keys_t press;

  modport ctl (output touched, output toggle, input active, input press);
  modport key (input touched, input toggle, output active, output press);
endinterface : tk_if

// ==== tk_sync.sv ====
`timescale 1ns/10ps
module tk_sync #(
  parameter int W = 19
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : tk_sync

// ==== tk_key_out.sv ====
`timescale 1ns/10ps
module tk_key_out (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Key state link
  tk_if.key ka
);
  import tk_pkg::*;

  tk_keys_t prev;
  tk_keys_t state;
  tk_keys_t next_state;

  assign ka.press = tk_rise(ka.touched, prev);
  assign ka.active = state;

  always_comb begin
    next_state = ka.toggle ? (state ^ ka.press) : ka.touched;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prev <= '0;
      state <= '0;
    end else begin
      prev <= ka.touched;
      state <= next_state;
    end
  end

  // Level style follows the input with one cycle of delay
  a_level_follow: assert property (
    @(posedge mclk) disable iff (!rst_n)
    !ka.toggle |=> (state == $past(ka.touched)))
    else $error("level output does not follow touch");

  // Toggle style flips exactly on the keys that saw a new touch
  a_toggle_flip: assert property (
    @(posedge mclk) disable iff (!rst_n)
    ka.toggle |=> ((state ^ $past(state)) == $past(ka.press)))
    else $error("toggle output changed on wrong key");
endmodule : tk_key_out

// ==== tk_top.sv ====
`include "tk_cfg.svh"
`timescale 1ns/10ps
module tk_top (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // APB slave
  input wire tk_pkg::tk_addr_t paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire tk_pkg::tk_data_t pwdata,
  output tk_pkg::tk_data_t prdata,
  output logic pready,
  output logic pslverr,
  // Touch pads and straps
  input wire tk_pkg::tk_keys_t touch_input,
  input wire logic key_scan_scope_select,
  input wire logic output_style_select,
  // Open-drain key outputs
  input wire tk_pkg::tk_keys_t key_output_in,
  output tk_pkg::tk_keys_t key_output_o,
  output tk_pkg::tk_keys_t key_output_oe,
  // One-wire serial line
  input wire logic one_wire_serial_line_in,
  output logic one_wire_serial_line_o,
  output logic one_wire_serial_line_oe,
  // Interrupt
  output logic irq
);
  import tk_pkg::*;

  localparam logic [11:0] BIT_LAST = 12'(`TK_BIT_CYCLES - 1);
  // Synchronised pins
  logic [18:0] sync_q;
  tk_keys_t touch_s;
  tk_keys_t pad_s;
  logic scope_s;
  logic style_s;
  logic ser_s;

  // Strap capture
  logic [1:0] strap_cnt;
  logic strap_done;
  logic strap_any;
  logic strap_toggle;

  // Control and effective mode
  logic ctrl_ovr;
  logic ctrl_any;
  logic ctrl_toggle;
  logic eff_any;
  logic eff_toggle;

  // Interrupts
  logic [8:0] int_stat;
  logic [8:0] int_mask;
  logic [8:0] int_set;
  logic [8:0] int_clr;

  // Serial engine
  tk_ser_t ser_state;
  logic [11:0] div_cnt;
  logic tick;
  logic [2:0] bit_idx;
  tk_keys_t snap;
  logic [2:0] cmd;
  logic [2:0] next_cmd;
  logic cmd_fire;
  logic ser_prev;

  // APB decode
  logic setup;
  logic wr_en;
  tk_data_t rd_word;

  tk_if ka ();
  tk_sync #(.W(19)) u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .d({one_wire_serial_line_in, output_style_select,
        key_scan_scope_select, key_output_in, touch_input}),
    .q(sync_q)
  );

  assign touch_s = sync_q[7:0];
  assign pad_s = sync_q[15:8];
  assign scope_s = sync_q[16];
  assign style_s = sync_q[17];
  assign ser_s = sync_q[18];

  // Straps are taken once the synchroniser holds post-reset levels;
  // later strap movement is ignored by design.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      strap_cnt <= 2'h0;
      strap_done <= 1'b0;
      strap_any <= 1'b0;
      strap_toggle <= 1'b0;
    end else if (!strap_done) begin
      strap_cnt <= strap_cnt + 2'h1;
      if (strap_cnt == `TK_STRAP_WAIT) begin
        strap_any <= ~scope_s;
        strap_toggle <= ~style_s;
        strap_done <= 1'b1;
      end
    end
  end

  assign eff_any = ctrl_ovr ? ctrl_any : strap_any;
  assign eff_toggle = ctrl_ovr ? ctrl_toggle : strap_toggle;

  assign ka.touched = eff_any ? touch_s : {7'h00, touch_s[0]};
  assign ka.toggle = eff_toggle;

  tk_key_out u_key (
    .mclk(mclk),
    .rst_n(rst_n),
    .ka(ka)
  );

  // Outputs stay released until the straps are known
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      key_output_o <= 8'h00;
      key_output_oe <= 8'h00;
    end else begin
      key_output_o <= 8'h00;
      key_output_oe <= strap_done ? ka.active : 8'h00;
    end
  end

  // Divider gives a one-cycle tick per serial bit, restarted per frame
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 12'h000;
      tick <= 1'b0;
    end else if (ser_state == SER_IDLE || ser_state == SER_START) begin
      div_cnt <= 12'h000;
      tick <= 1'b0;
    end else if (div_cnt == BIT_LAST) begin
      div_cnt <= 12'h000;
      tick <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 12'h001;
      tick <= 1'b0;
    end
  end

  // Host bits are active low, like the straps
  assign next_cmd = {~ser_s, cmd[2:1]};
  assign cmd_fire = (ser_state == SER_CMD) && tick &&
                    (bit_idx == `TK_CMD_LAST);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ser_state <= SER_IDLE;
      bit_idx <= 3'h0;
      snap <= 8'h00;
      cmd <= 3'h0;
      ser_prev <= 1'b1;
    end else begin
      ser_prev <= ser_s;
      case (ser_state)
        SER_IDLE: begin
          // Falling edge only: a low last command slot is no new start
          if (!ser_s && ser_prev && strap_done) begin
            ser_state <= SER_START;
          end
        end
        SER_START: begin
          if (ser_s) begin
            snap <= ka.active;
            bit_idx <= 3'h0;
            ser_state <= SER_SEND;
          end
        end
        SER_SEND: begin
          if (tick) begin
            if (bit_idx == `TK_STAT_LAST) begin
              bit_idx <= 3'h0;
              ser_state <= SER_CMD;
            end else begin
              bit_idx <= bit_idx + 3'h1;
            end
          end
        end
        SER_CMD: begin
          if (tick) begin
            cmd <= next_cmd;
            if (bit_idx == `TK_CMD_LAST) begin
              bit_idx <= 3'h0;
              ser_state <= SER_IDLE;
            end else begin
              bit_idx <= bit_idx + 3'h1;
            end
          end
        end
        default: begin
          ser_state <= SER_IDLE;
        end
      endcase
    end
  end

  // A zero status bit is sent by pulling the line low for a bit time
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      one_wire_serial_line_o <= 1'b0;
      one_wire_serial_line_oe <= 1'b0;
    end else begin
      one_wire_serial_line_o <= 1'b0;
      one_wire_serial_line_oe <= (ser_state == SER_SEND) &&
                                 !snap[bit_idx];
    end
  end

  // APB access phase always completes in its first cycle
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pready && pwrite;

  // Control: serial command applied after a same-cycle bus write
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ovr <= 1'b0;
      ctrl_any <= 1'b0;
      ctrl_toggle <= 1'b0;
    end else begin
      if (wr_en && paddr == `TK_ADDR_CTRL) begin
        ctrl_ovr <= pwdata[`TK_CTRL_OVR];
        ctrl_any <= pwdata[`TK_CTRL_SCOPE];
        ctrl_toggle <= pwdata[`TK_CTRL_STYLE];
      end
      if (cmd_fire && next_cmd[0]) begin
        ctrl_ovr <= 1'b1;
        ctrl_any <= next_cmd[1];
        ctrl_toggle <= next_cmd[2];
      end
    end
  end

  assign int_set = {cmd_fire, ka.press};
  assign int_clr = (wr_en && paddr == `TK_ADDR_INT_STAT) ?
                   pwdata[8:0] : 9'h000;

  // New events win over a write-one clear in the same cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      int_stat <= `TK_INT_RST;
    end else begin
      int_stat <= (int_stat & ~int_clr) | int_set;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      int_mask <= `TK_MASK_RST;
    end else if (wr_en && paddr == `TK_ADDR_INT_MASK) begin
      int_mask <= pwdata[8:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(int_stat & int_mask);
    end
  end

  always_comb begin
    rd_word = 32'h0000_0000;
    case (paddr)
      `TK_ADDR_CTRL: begin
        rd_word[`TK_CTRL_OVR] = ctrl_ovr;
        rd_word[`TK_CTRL_SCOPE] = ctrl_any;
        rd_word[`TK_CTRL_STYLE] = ctrl_toggle;
      end
      `TK_ADDR_STATUS: begin
        rd_word = {12'h000, strap_toggle, strap_any, eff_toggle,
                   eff_any, pad_s, ka.active};
      end
      `TK_ADDR_INT_STAT: begin
        rd_word = {23'h000000, int_stat};
      end
      `TK_ADDR_INT_MASK: begin
        rd_word = {23'h000000, int_mask};
      end
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // Read data and response are latched in the setup cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (setup) begin
      pready <= 1'b1;
      pslverr <= !tk_mapped(paddr);
      prdata <= pwrite ? 32'h0000_0000 : rd_word;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  sequence s_frame_start;
    ser_state == SER_START ##1 ser_state == SER_SEND;
  endsequence
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  a_strap_hold: assert property (
    strap_done |=> $stable(strap_any) && $stable(strap_toggle))
    else $error("strap level changed after capture");
  a_scope_one: assert property (
    !eff_any |-> ka.touched[7:1] == 7'h00)
    else $error("one-key scope let a high key through");
  a_style_strap: assert property (
    strap_done && !ctrl_ovr |-> ka.toggle == strap_toggle)
    else $error("style does not follow strap");
  a_cmd_override: assert property (
    cmd_fire && next_cmd[0] |=> ctrl_ovr &&
      eff_any == $past(next_cmd[1]) &&
      eff_toggle == $past(next_cmd[2]))
    else $error("serial command not applied");
  a_ser_first: assert property (
    s_frame_start |=> one_wire_serial_line_oe == !snap[0])
    else $error("first status bit wrong on serial line");
  a_pin_status: assert property (
    strap_done |=> key_output_oe == $past(ka.active))
    else $error("key output pin disagrees with status");
  a_drain_only: assert property (
    key_output_o == 8'h00 && !one_wire_serial_line_o)
    else $error("open-drain pin driven high");
  a_irq_raise: assert property (
    |(int_set & int_mask) |-> ##[1:2] irq)
    else $error("interrupt not raised");
  a_apb_ready: assert property (
    setup |=> pready ##1 !pready)
    else $error("apb ready timing wrong");
endmodule : tk_top

// ==== tk_mcu.sv ====
`timescale 1ns/10ps
module tk_mcu (
  // Clock and serial line
  input wire logic mclk,
  input wire logic line,
  output logic pull
);
  import tk_pkg::*;
  initial pull = 1'b0;
  task automatic frame(input logic [2:0] cmd, output tk_keys_t st);
    @(posedge mclk);
    pull <= 1'b1;
    repeat (4) @(posedge mclk);
    pull <= 1'b0;
    // Mid-bit sampling keeps the sync delay out of the way
    repeat (1000) @(posedge mclk);
    for (int k = 0; k < 8; k++) begin
      st[k] = line;
      repeat (2000) @(posedge mclk);
    end
    // Each command level sits across the end of its slot
    for (int j = 0; j < 3; j++) begin
      pull <= cmd[j];
      repeat (2000) @(posedge mclk);
    end
    pull <= 1'b0;
  endtask : frame
endmodule : tk_mcu

// ==== tb_top.sv ====
`timescale 1ns/10ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
  import tk_pkg::*;
  logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, irq;
  logic so, soe, pull, kscope, ostyle;
  tk_addr_t paddr;
  tk_data_t pwdata, prdata;
  tk_keys_t touch, ko, koe, t, s;
  // Pull-ups on the open-drain pads and the serial line
  wire tk_keys_t kpad = ~koe;
  wire line = ~(soe | pull);
  int n_errors = 0;
  int num_checks = 0;
  int seed = 32'haad75260;
  logic [32:0] expq[$];

  tk_top dut (.mclk(mclk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .touch_input(touch),
    .key_scan_scope_select(kscope), .output_style_select(ostyle),
    .key_output_in(kpad), .key_output_o(ko), .key_output_oe(koe),
    .one_wire_serial_line_in(line), .one_wire_serial_line_o(so),
    .one_wire_serial_line_oe(soe), .irq(irq));
  tk_mcu host (.mclk(mclk), .line(line), .pull(pull));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task end_sim;
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim

  task automatic apb(input logic w, input tk_addr_t a, input tk_data_t d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge mclk);
    end
    if (n == 20) n_errors++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input tk_addr_t a, input tk_data_t d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input tk_addr_t a, input logic [32:0] e);
    expq.push_back(e);
    apb(1'b0, a, 32'h0000_0000);
  endtask : rd

  function automatic logic [32:0] st(input logic [3:0] m, input tk_keys_t k);
    return {13'h0000, m, ~k, k};
  endfunction : st

  task automatic kc(input tk_keys_t tv, input tk_keys_t e);
    touch <= tv;
    repeat (8) @(posedge mclk);
    `CHK({so, ko, koe}, {9'h000, e}) // drive low only
  endtask : kc

  task automatic rst(input logic lvl);
    rst_n <= 1'b0;
    kscope <= lvl;
    ostyle <= lvl;
    touch <= 8'h00;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (12) @(posedge mclk);
  endtask : rst

  always @(posedge mclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (expq.size() == 0)
        n_errors++;
      else
        `CHK({pslverr, prdata}, expq.pop_front()) // read data
    end
  end

  initial begin
    #400000;
    n_errors++;
    end_sim;
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    rst(1'b1);
    rd(12'h000, 33'h0); // no override at reset
    rd(12'h008, 33'h0); // no events
    rd(12'h00C, 33'h0); // mask clear
    rd(12'h010, {1'b1, 32'h0}); // unmapped refused
    rd(12'h004, st(4'h0, 8'h00)); // straps high
    repeat (6) begin
      t = 8'($random(seed));
      kc(t, {7'h00, t[0]}); // key zero only
    end
    wr(12'h00C, 32'h1FF);
    wr(12'h008, 32'h1FF);
    rd(12'h008, 33'h0); // cleared
    kc(8'h00, 8'h00); // released
    kc(8'h03, 8'h01); // key one ignored
    `CHK(irq, 1'b1) // event raised
    rd(12'h008, 33'h1); // only key zero event
    wr(12'h00C, 32'h0);
    repeat (3) @(posedge mclk);
    `CHK(irq, 1'b0) // masked
    wr(12'h008, 32'h1);
    rd(12'h008, 33'h0); // one clears
    wr(12'h00C, 32'h1FF);
    repeat (3) @(posedge mclk);
    `CHK(irq, 1'b0) // nothing pending
    touch <= 8'h01;
    host.frame(3'b011, s);
    `CHK(s, 8'h01) // status on line
    repeat (8) @(posedge mclk);
    rd(12'h004, st(4'b0001, 8'h01)); // any-key commanded
    rd(12'h008, 33'h100); // command event
    `CHK(irq, 1'b1) // command event
    kc(8'h81, 8'h81); // all keys scanned
    host.frame(3'b110, s);
    `CHK(s, 8'h81) // status on line
    repeat (8) @(posedge mclk);
    rd(12'h004, st(4'b0001, 8'h81)); // unapplied command
    rst(1'b0);
    rd(12'h004, st(4'hF, 8'h00)); // straps low
    kc(8'h08, 8'h08); // toggle on
    kc(8'h00, 8'h08); // held after release
    kc(8'h20, 8'h28); // own index only
    kc(8'h00, 8'h28); // held
    kc(8'h08, 8'h20); // toggle off
    wr(12'h000, 32'h7);
    rd(12'h000, 33'h7); // control readback
    wr(12'h000, 32'h3);
    kc(8'h41, 8'h41); // level commanded
    rd(12'h004, st(4'b1101, 8'h41)); // effective mode
    end_sim;
  end
endmodule : tb_top
